// ==== core/mfpc_pin_ctrl.sv ====
// Purpose: Pin level control of a multi-line serial flash interface
// Assumes: Frame layout inputs are stable across a whole frame
// Notes: Link logic runs on sck_i; status and reset logic on sys_clk_i
`timescale 1ns/1ps
`include "mfpc_regs.svh"

module mfpc_pin_ctrl #(
    parameter int RESET_PULSE_NS = `MFPC_RESET_PULSE_NS,
    parameter int PARK_NS = `MFPC_PARK_NS
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic [3:0] io_i,
    output logic [3:0] io_o,
    output logic [3:0] io_oe_o,
    input wire logic [7:0] config1_volatile_i,
    input wire logic [7:0] config2_volatile_i,
    input wire logic [7:0] status1_nonvolatile_i,
    input wire logic four_wire_instruction_mode_i,
    input wire mfpc_pkg::mfpc_width_t width_i,
    input wire logic ddr_i,
    input wire logic read_frame_i,
    input wire logic [7:0] in_cycles_i,
    input wire logic [7:0] tx_byte_i,
    input wire logic tx_load_i,
    output logic tx_ready_o,
    output logic [7:0] rx_byte_o,
    output logic rx_valid_o,
    output logic rx_is_instr_o,
    output logic frame_active_o,
    input wire logic op_start_i,
    input wire logic op_done_i,
    output logic write_in_progress_o,
    input wire logic write_any_register_cmd_i,
    input wire mfpc_pkg::mfpc_target_t reg_target_i,
    output logic reg_write_grant_o,
    output logic hw_reset_o
);
    import mfpc_pkg::*;

    localparam int CLK_NS = `MFPC_CLK_PERIOD_NS;
    localparam int RP_RAW = (RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RP_CYC = (RP_RAW < 1) ? 1 : RP_RAW;
    localparam int PK_RAW = PARK_NS / CLK_NS;
    localparam int PK_CYC = (PK_RAW < 1) ? 1 : PK_RAW;
    localparam int CW = $clog2(RP_CYC + PK_CYC + 2);

    // ------------------------------------------------------------
    // Link side: configuration crossing
    // ------------------------------------------------------------
    // Async clear while deselected; sck stops between frames
    wire frame_rst_n = rst_n_i & ~cs_n_i;
    wire [`MFPC_CFG_W-1:0] cfg_in = {in_cycles_i, width_i, ddr_i,
        read_frame_i, four_wire_instruction_mode_i,
        config1_volatile_i[`MFPC_CR1_QUAD_BIT]};
    logic [`MFPC_CFG_W-1:0] cfg_s1_reg, cfg_s2_reg;
    always_ff @(posedge sck_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_s1_reg <= '0;
            cfg_s2_reg <= '0;
        end else begin
            cfg_s1_reg <= cfg_in;
            cfg_s2_reg <= cfg_s1_reg;
        end
    end
    wire s_quad = cfg_s2_reg[0];
    wire s_fourw = cfg_s2_reg[1];
    wire s_read = cfg_s2_reg[2];
    wire s_ddr = cfg_s2_reg[3];
    wire mfpc_width_t s_width = mfpc_width_t'(cfg_s2_reg[5:4]);
    wire [7:0] s_cycles = cfg_s2_reg[13:6];
    // Upper lanes only in quad or four-wire use
    wire wide_ok = s_quad | s_fourw;

    // ------------------------------------------------------------
    // Link side: receive
    // ------------------------------------------------------------
    mfpc_phase_t phase_reg;
    logic [7:0] shift_reg, cyc_reg;
    logic [3:0] bits_reg, fall_reg, rise_reg;
    logic ddr_seen_reg;
    // Instruction on line 0 unless four-wire
    wire mfpc_width_t cur_w = (phase_reg != MFPC_PH_INSTR) ? s_width :
        (s_fourw ? MFPC_W4 : MFPC_W1);
    wire [3:0] step = (cur_w == MFPC_W4 && wide_ok) ? 4'h4 :
        (cur_w == MFPC_W1) ? 4'h1 : 4'h2;
    // Lowest bit of a group on line 0
    wire [3:0] grp_now = io_i & {wide_ok, wide_ok, 2'b11};
    wire [3:0] grp_fall = fall_reg & {wide_ok, wide_ok, 2'b11};
    wire [7:0] sh_one = (step == 4'h1) ? {shift_reg[6:0], grp_now[0]} :
        (step == 4'h2) ? {shift_reg[5:0], grp_now[1:0]} :
        {shift_reg[3:0], grp_now};
    wire [7:0] sh_two = (step == 4'h1) ?
        {shift_reg[5:0], rise_reg[0], grp_fall[0]} :
        (step == 4'h2) ? {shift_reg[3:0], rise_reg[1:0], grp_fall[1:0]} :
        {rise_reg, grp_fall};
    // Rising edge capture, falling too in DDR
    wire two_grp = s_ddr & ddr_seen_reg & (phase_reg == MFPC_PH_IN);
    // First DDR rise only keeps its group so bytes stay pair aligned;
    // the last pair of a frame needs one more rise to land
    wire ddr_first = s_ddr & ~ddr_seen_reg & (phase_reg == MFPC_PH_IN);
    wire [3:0] bits_add = two_grp ? {step[2:0], 1'b0} :
        (ddr_first ? 4'h0 : step);
    wire [3:0] bits_sum = bits_reg + bits_add;
    wire take_in = (phase_reg != MFPC_PH_OUT);
    // First eight bits form the instruction
    wire byte_done = take_in & (bits_sum >= `MFPC_INSTR_BITS);
    wire [7:0] byte_val = two_grp ? sh_two : sh_one;
    wire last_cyc = (cyc_reg + 8'h01 >= s_cycles);
    mfpc_phase_t phase_next;
    assign phase_next =
        (phase_reg == MFPC_PH_INSTR && byte_done) ?
            ((s_read && s_cycles == 8'h00) ? MFPC_PH_OUT : MFPC_PH_IN) :
        (phase_reg == MFPC_PH_IN && s_read && last_cyc) ? MFPC_PH_OUT :
        phase_reg;

    always_ff @(negedge sck_i or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            fall_reg <= 4'h0;
        end else begin
            fall_reg <= io_i;
        end
    end

    always_ff @(posedge sck_i or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            phase_reg <= MFPC_PH_INSTR;
            shift_reg <= 8'h00;
            bits_reg <= 4'h0;
            cyc_reg <= 8'h00;
            ddr_seen_reg <= 1'b0;
            rise_reg <= 4'h0;
        end else begin
            phase_reg <= phase_next;
            rise_reg <= grp_now;
            shift_reg <= (take_in && !ddr_first) ? byte_val : shift_reg;
            bits_reg <= byte_done ? 4'h0 : (take_in ? bits_sum : bits_reg);
            cyc_reg <= (phase_reg == MFPC_PH_IN) ? cyc_reg + 8'h01 : 8'h00;
            ddr_seen_reg <= (phase_reg == MFPC_PH_IN);
        end
    end

    logic [7:0] rx_hold_reg;
    logic rx_tog_reg, rx_instr_reg, drove_reg;
    always_ff @(posedge sck_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_hold_reg <= 8'h00;
            rx_tog_reg <= 1'b0;
            rx_instr_reg <= 1'b0;
            drove_reg <= 1'b0;
        end else begin
            if (byte_done) begin
                rx_hold_reg <= byte_val;
                rx_tog_reg <= ~rx_tog_reg;
                rx_instr_reg <= (phase_reg == MFPC_PH_INSTR);
            end
            // Remembers a read frame until the next one starts
            if (phase_reg == MFPC_PH_OUT && !cs_n_i) begin
                drove_reg <= 1'b1;
            end else if (phase_reg == MFPC_PH_INSTR && bits_reg == 4'h0) begin
                drove_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Link side: transmit
    // ------------------------------------------------------------
    logic [7:0] tx_hold_reg, out_sh_reg;
    logic tx_tog_reg, txs1_reg, txs2_reg, tx_ack_reg;
    always_ff @(negedge sck_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            txs1_reg <= 1'b0;
            txs2_reg <= 1'b0;
        end else begin
            txs1_reg <= tx_tog_reg;
            txs2_reg <= txs1_reg;
        end
    end
    logic [3:0] obits_reg, out_neg_reg, stage_reg, out_pos_reg, oe_reg;
    wire out_now = (phase_reg == MFPC_PH_OUT);
    wire [3:0] out_step = s_ddr ? {step[2:0], 1'b0} : step;
    wire load_byte = out_now & (obits_reg == 4'h0);
    wire [7:0] src = load_byte ? tx_hold_reg : out_sh_reg;
    wire tx_take = load_byte & (txs2_reg != tx_ack_reg);
    // Single-bit reads leave on line 1
    function automatic logic [3:0] grp_at(input logic [7:0] v,
                                          input logic [3:0] st);
        grp_at = (st == 4'h1) ? {2'b00, v[7], 1'b0} :
            (st == 4'h2) ? {2'b00, v[7:6]} : v[7:4];
    endfunction
    wire [7:0] src_sh = (step == 4'h1) ? {src[6:0], 1'b0} :
        (step == 4'h2) ? {src[5:0], 2'b00} : {src[3:0], 4'h0};
    wire [7:0] sh_after = s_ddr ?
        ((step == 4'h1) ? {src[5:0], 2'b00} :
         (step == 4'h2) ? {src[3:0], 4'h0} : 8'h00) : src_sh;
    // Drive only the lanes of the read width
    wire [3:0] oe_mask = (step == 4'h1) ? 4'h2 :
        (step == 4'h2) ? 4'h3 : 4'hf;

    always_ff @(negedge sck_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_ack_reg <= 1'b0;
        end else if (tx_take) begin
            tx_ack_reg <= txs2_reg;
        end
    end

    // Outputs change after the falling edge
    always_ff @(negedge sck_i or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            out_sh_reg <= 8'h00;
            obits_reg <= 4'h0;
            out_neg_reg <= 4'h0;
            stage_reg <= 4'h0;
            oe_reg <= 4'h0;
        end else begin
            out_sh_reg <= out_now ? sh_after : out_sh_reg;
            obits_reg <= out_now ? ((load_byte ? `MFPC_INSTR_BITS :
                obits_reg) - out_step) : 4'h0;
            out_neg_reg <= out_now ? grp_at(src, step) : 4'h0;
            stage_reg <= out_now ? grp_at(src_sh, step) : 4'h0;
            oe_reg <= out_now ? oe_mask : 4'h0;
        end
    end

    // DDR second group after the rising edge
    always_ff @(posedge sck_i or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            out_pos_reg <= 4'h0;
        end else begin
            out_pos_reg <= stage_reg;
        end
    end

    // ------------------------------------------------------------
    // System side: crossings
    // ------------------------------------------------------------
    logic cs_s1_reg, cs_s2_reg, cs_prev_reg;
    logic [3:2] io_s1_reg, io_s2_reg;
    logic rx_s1_reg, rx_s2_reg, rx_s3_reg, ack_s1_reg, ack_s2_reg;
    logic rd_s1_reg, rd_s2_reg;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            cs_prev_reg <= 1'b1;
            io_s1_reg <= 2'b11;
            io_s2_reg <= 2'b11;
            {rx_s1_reg, rx_s2_reg, rx_s3_reg} <= 3'h0;
            {ack_s1_reg, ack_s2_reg, rd_s1_reg, rd_s2_reg} <= 4'h0;
        end else begin
            cs_s1_reg <= cs_n_i;
            cs_s2_reg <= cs_s1_reg;
            cs_prev_reg <= cs_s2_reg;
            io_s1_reg <= io_i[3:2];
            io_s2_reg <= io_s1_reg;
            {rx_s1_reg, rx_s2_reg, rx_s3_reg} <=
                {rx_tog_reg, rx_s1_reg, rx_s2_reg};
            {ack_s1_reg, ack_s2_reg} <= {tx_ack_reg, ack_s1_reg};
            {rd_s1_reg, rd_s2_reg} <= {drove_reg, rd_s1_reg};
        end
    end

    // ------------------------------------------------------------
    // System side: park, reset, busy, write filter
    // ------------------------------------------------------------
    wire quad = config1_volatile_i[`MFPC_CR1_QUAD_BIT];
    wire cs_rise = cs_s2_reg & ~cs_prev_reg;
    logic [CW-1:0] park_cnt_reg, rp_cnt_reg;
    wire park_on = (park_cnt_reg != '0);
    // Pin has a reset role only when enabled
    // Read as reset when quad off or deselected
    wire rst_role = config2_volatile_i[`MFPC_CR2_RST_EN_BIT] &
        (~quad | cs_s2_reg);
    // Select high and pin low together
    wire rst_cond = rst_role & cs_s2_reg & ~io_s2_reg[3] & ~park_on;
    wire rp_hit = rst_cond & (rp_cnt_reg == CW'(RP_CYC - 1));
    // Protect pin only outside quad mode
    wire wp_low = ~quad & ~io_s2_reg[2];
    // Status and config one targets are shielded
    wire shielded = (reg_target_i != MFPC_T_OTHER);
    wire wr_block = wp_low & status1_nonvolatile_i[`MFPC_SR1_SWD_BIT] &
        shielded;
    wire rx_event = rx_s2_reg ^ rx_s3_reg;
    logic wip_reg, grant_reg, hw_rst_reg, rx_valid_reg, rx_instr_o_reg;
    logic tx_ready_reg, frame_reg;
    logic [7:0] rx_byte_reg;
    wire tx_accept = tx_load_i & tx_ready_reg;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            park_cnt_reg <= '0;
            rp_cnt_reg <= '0;
            {wip_reg, grant_reg, hw_rst_reg, frame_reg} <= 4'h0;
        end else begin
            // Hold IO3 high for a while after a read
            park_cnt_reg <= (cs_rise && rd_s2_reg) ? CW'(PK_CYC) :
                (park_on && cs_s2_reg) ? park_cnt_reg - 1'b1 : '0;
            // One step past the hit so the pulse does not repeat
            rp_cnt_reg <= !rst_cond ? '0 :
                (rp_cnt_reg == CW'(RP_CYC)) ? rp_cnt_reg :
                rp_cnt_reg + 1'b1;
            hw_rst_reg <= rp_hit;
            // Start wins over a same-cycle finish
            wip_reg <= op_start_i | (wip_reg & ~op_done_i);
            grant_reg <= write_any_register_cmd_i & ~wr_block;
            frame_reg <= ~cs_s2_reg;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_byte_reg <= 8'h00;
            {rx_valid_reg, rx_instr_o_reg} <= 2'b00;
            tx_hold_reg <= 8'h00;
            tx_tog_reg <= 1'b0;
            tx_ready_reg <= 1'b0;
        end else begin
            rx_byte_reg <= rx_event ? rx_hold_reg : rx_byte_reg;
            rx_valid_reg <= rx_event;
            rx_instr_o_reg <= rx_event ? rx_instr_reg : rx_instr_o_reg;
            tx_hold_reg <= tx_accept ? tx_byte_i : tx_hold_reg;
            tx_tog_reg <= tx_tog_reg ^ tx_accept;
            tx_ready_reg <= ~tx_accept & ((tx_tog_reg ^ tx_accept)
                == ack_s2_reg);
        end
    end

    // Pin muxes pick between flops; the park drive only owns IO3
    wire ddr_pos = s_ddr & sck_i;
    assign io_o = park_on ? {1'b1, 3'h0} :
        (ddr_pos ? out_pos_reg : out_neg_reg);
    assign io_oe_o = park_on ? 4'h8 : oe_reg;
    assign tx_ready_o = tx_ready_reg;
    assign rx_byte_o = rx_byte_reg;
    assign rx_valid_o = rx_valid_reg;
    assign rx_is_instr_o = rx_instr_o_reg;
    assign frame_active_o = frame_reg;
    assign write_in_progress_o = wip_reg;
    assign reg_write_grant_o = grant_reg;
    assign hw_reset_o = hw_rst_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic [CW-1:0] low_run_reg;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            low_run_reg <= '0;
        end else begin
            low_run_reg <= (cs_s2_reg && !io_s2_reg[3]) ?
                ((low_run_reg == '1) ? low_run_reg : low_run_reg + 1'b1) :
                '0;
        end
    end

    a_wip_set: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        op_start_i |=> write_in_progress_o) else $error("busy not set");
    a_wip_clear: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        (write_in_progress_o && op_done_i && !op_start_i)
        |=> !write_in_progress_o) else $error("busy not cleared");
    a_wp_block: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        (write_any_register_cmd_i && wp_low && shielded &&
         status1_nonvolatile_i[`MFPC_SR1_SWD_BIT]) |=> !reg_write_grant_o)
        else $error("protected write granted");
    a_wp_quad: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        (write_any_register_cmd_i && quad) |=> reg_write_grant_o)
        else $error("quad write refused");
    a_rst_enable: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        hw_reset_o |-> $past(config2_volatile_i[`MFPC_CR2_RST_EN_BIT]))
        else $error("reset while disabled");
    a_rst_length: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        hw_reset_o |-> low_run_reg >= CW'(RP_CYC))
        else $error("reset pulse too short");
    a_rst_single: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        hw_reset_o |=> !hw_reset_o)
        else $error("reset pulse repeated");
    a_rst_cs_high: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        hw_reset_o |-> $past(cs_s2_reg, 2) && $past(cs_s2_reg))
        else $error("reset seen while selected");
    a_park_drive: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        (cs_rise && rd_s2_reg) |=> (io_oe_o == 4'h8) && io_o[3])
        else $error("IO3 not parked high");
    a_oe_idle: assert property (@(posedge sck_i)
        disable iff (!frame_rst_n)
        (phase_reg != MFPC_PH_OUT && $past(phase_reg) != MFPC_PH_OUT)
        |-> oe_reg == 4'h0) else $error("lane driven while receiving");
    a_oe_quad: assert property (@(posedge sck_i)
        disable iff (!frame_rst_n)
        (phase_reg == MFPC_PH_OUT && $past(phase_reg) == MFPC_PH_OUT &&
         s_width == MFPC_W4 && wide_ok) |-> oe_reg == 4'hf)
        else $error("quad lanes not driven");
endmodule

// ==== shared/mfpc_pkg.sv ====
// Purpose: Types shared by the pin control core and its bench
// Assumes: Nothing beyond the constants header
// Notes: Widths count data lines per group
package mfpc_pkg;
    typedef enum logic [1:0] {MFPC_W1, MFPC_W2, MFPC_W4} mfpc_width_t;
    typedef enum logic [1:0] {MFPC_PH_INSTR, MFPC_PH_IN, MFPC_PH_OUT}
        mfpc_phase_t;
    typedef enum logic [2:0] {
        MFPC_T_STATUS1_NV, MFPC_T_STATUS1_V, MFPC_T_CONFIG1_NV,
        MFPC_T_CONFIG1_V, MFPC_T_OTHER
    } mfpc_target_t;
endpackage

// ==== shared/mfpc_regs.svh ====
// Purpose: Bit positions, widths and timing figures for the pin control
// Assumes: Included by bare name wherever the constants are needed
// Notes: Times in ns; cycle counts are derived in the core
//
// How it works
// - Quad bit and select low make IO3 data
// - Reset role exists only with reset enable
// - Reset pin read when quad off or deselected
// - Reset needs select high, pin low, pulse time
// - Device parks IO3 high after reads
// - Deselected: data inputs ignored, outputs released once the IO3 park ends
// - Busy flag set through each embedded operation
// - Sample on rise, drive on fall or both
// - Single-bit: in on line 0, out on 1
// - Dual/quad: instruction line 0, rest grouped
// - Four-wire mode: everything as nibbles; the core takes only the instruction as nibbles, data follows width_i
// - Protect pin low blocks status/config writes
// - Quad mode turns protect pin into IO2
// - Low bit on line 0, groups MSB first
`ifndef MFPC_REGS_SVH
`define MFPC_REGS_SVH

`define MFPC_CR1_QUAD_BIT 1
`define MFPC_CR2_RST_EN_BIT 5
`define MFPC_SR1_SWD_BIT 7
`define MFPC_INSTR_BITS 4'h8
`define MFPC_CFG_W 14
`define MFPC_CLK_PERIOD_NS 100
`define MFPC_RESET_PULSE_NS 1000
`define MFPC_PARK_NS 200

`endif

// ==== test/mfpc_host_model.sv ====
// Purpose: Host controller model on the far side of the flash link
// Assumes: Clock mode 0; link clock stands still between bytes
// Notes: Released lanes are resolved by the bench, not here
`timescale 1ns/1ps

module mfpc_host_model (
    output logic sck_o,
    output logic cs_n_o,
    output logic [3:0] hio_o,
    output logic [3:0] hoe_o,
    input wire logic [3:0] pin_i
);
    // ------------------------------------------------------------
    // Pin tasks
    // ------------------------------------------------------------
    // idle low, own reset line
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        hio_o = 4'hf;
        hoe_o = 4'hc;
    end

    task automatic pins(input logic [3:0] v, input logic [3:0] oe);
        hio_o = v;
        hoe_o = oe;
    endtask

    task automatic sel();
        // Deselected clocks let the core pick up the frame setup
        repeat (2) begin
            #3 sck_o = 1'b1;
            #3 sck_o = 1'b0;
        end
        cs_n_o = 1'b0;
        #10;
    endtask

    task automatic send(input logic [7:0] b, input int w, input bit ddr);
        for (int i = 8 / w - 1; i >= 0; i--) begin
            #1 hio_o = 4'((b >> (i * w)) & ((1 << w) - 1));
            hoe_o = 4'((1 << w) - 1);
            #2 sck_o = ~sck_o;
            if (!ddr) #3 sck_o = ~sck_o;
        end
        // Pause keeps byte rate below the system sampling rate
        #500;
    endtask

    task automatic recv(input int w, input int dum, output logic [7:0] b);
        hoe_o = 4'h0;
        b = 8'h00;
        for (int i = 0; i < dum + 8 / w; i++) begin
            #3 sck_o = 1'b1;
            if (i >= dum && w == 1) b = {b[6:0], pin_i[1]};
            else if (i >= dum) b = 8'((b << w) | (pin_i & 4'((1 << w) - 1)));
            #3 sck_o = 1'b0;
        end
        #500;
    endtask

    task automatic desel(input logic drv);
        #3 cs_n_o = 1'b1;
        hio_o = 4'hf;
        hoe_o = drv ? 4'hc : 4'h0;
    endtask
endmodule

// ==== test/test_mfpc_pin_ctrl.sv ====
// Purpose: Self-checking bench of the pin control core
// Assumes: Host model drives link pins; bench drives the rest
// Notes: Reset pulse shortened to three system cycles
`timescale 1ns/1ps

module test_mfpc_pin_ctrl;
    import mfpc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic tog = 1'b0;
    logic sck, cs_n, txr, rxv, rxi, fact, wip, grant, hwr;
    logic [3:0] hio, hoe, pin, io_o, io_oe;
    logic [7:0] cfg1 = 8'h00, cfg2 = 8'h00, st1 = 8'h00, rxb;
    logic [7:0] tx = 8'h00, icyc = 8'h00;
    logic fw = 1'b0, ddr = 1'b0, rd = 1'b0, txl = 1'b0;
    logic ops = 1'b0, opd = 1'b0, wreq = 1'b0;
    mfpc_width_t wid = MFPC_W1;
    mfpc_target_t tgt = MFPC_T_OTHER;
    int n_fail = 0, checked = 0, n_grant = 0, n_rst = 0;
    logic [8:0] rxq[$];

    // ------------------------------------------------------------
    // Wiring
    // ------------------------------------------------------------
    // lanes resolved from all drivers
    always_comb begin
        for (int k = 0; k < 4; k++)
            pin[k] = io_oe[k] ? io_o[k] : hoe[k] ? hio[k] : (k > 1 | tog);
    end

    mfpc_host_model host (.sck_o(sck), .cs_n_o(cs_n), .hio_o(hio),
        .hoe_o(hoe), .pin_i(pin));

    mfpc_pin_ctrl #(.RESET_PULSE_NS(300)) DUT (.sys_clk_i(sys_clk),
        .rst_n_i(rst_n), .sck_i(sck), .cs_n_i(cs_n), .io_i(pin),
        .io_o(io_o), .io_oe_o(io_oe), .config1_volatile_i(cfg1),
        .config2_volatile_i(cfg2), .status1_nonvolatile_i(st1),
        .four_wire_instruction_mode_i(fw), .width_i(wid), .ddr_i(ddr),
        .read_frame_i(rd), .in_cycles_i(icyc), .tx_byte_i(tx),
        .tx_load_i(txl), .tx_ready_o(txr), .rx_byte_o(rxb),
        .rx_valid_o(rxv), .rx_is_instr_o(rxi), .frame_active_o(fact),
        .op_start_i(ops), .op_done_i(opd), .write_in_progress_o(wip),
        .write_any_register_cmd_i(wreq), .reg_target_i(tgt),
        .reg_write_grant_o(grant), .hw_reset_o(hwr));

    initial begin
        forever #50 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        tog <= ~tog;
        if (rxv === 1'b1) rxq.push_back({rxi, rxb});
        if (grant === 1'b1) n_grant++;
        if (hwr === 1'b1) n_rst++;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic cmp(input string s, input logic [8:0] e, g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic wframe(input mfpc_width_t w, input logic f, d, q);
        logic [7:0] b0, b1;
        b0 = 8'($urandom);
        b1 = 8'($urandom);
        wid = w;
        fw = f;
        ddr = d;
        rd = 1'b0;
        cfg1 = {6'h00, q, 1'b0};
        rxq.delete();
        cyc(3);
        host.sel();
        host.send(b0, f ? 4 : 1, 1'b0);
        host.send(b1, 1 << int'(w), d);
        host.send(~b1, 1 << int'(w), d);
        host.desel(1'b1);
        cyc(4);
        while (rxq.size() < 2) rxq.push_back(9'bx);
        cmp("instr", {1'b1, b0}, rxq[0]);
        cmp("data", {1'b0, b1}, rxq[1]);
    endtask

    task automatic rframe(input mfpc_width_t w, input int ic);
        logic [7:0] b, got;
        logic seen;
        b = 8'($urandom);
        wid = w;
        rd = 1'b1;
        fw = 1'b0;
        ddr = 1'b0;
        icyc = 8'(ic);
        cfg1 = {6'h00, w == MFPC_W4, 1'b0};
        for (int i = 0; i < 20 && txr !== 1'b1; i++) cyc(1);
        tx = b;
        txl = 1'b1;
        cyc(1);
        txl = 1'b0;
        cmp("tx ready", 9'h0, {8'h00, txr});
        cyc(2);
        host.sel();
        host.send(8'($urandom), 1, 1'b0);
        host.recv(1 << int'(w), ic, got);
        cmp("read", {1'b0, b}, {1'b0, got});
        host.desel(1'b0);
        seen = 1'b0;
        repeat (6) begin
            @(negedge sys_clk);
            if (io_oe === 4'h8 && io_o[3] === 1'b1) seen = 1'b1;
        end
        cmp("park", 9'h1, {8'h00, seen});
        cyc(6);
        cmp("released", 9'h0, {5'h00, io_oe});
    endtask

    task automatic regw(input logic q, wp, sw, input mfpc_target_t t);
        int g0;
        logic blk;
        cfg1 = {6'h00, q, 1'b0};
        st1 = {sw, 7'h00};
        tgt = t;
        host.pins({1'b1, wp, 2'b11}, 4'hc);
        cyc(4);
        g0 = n_grant;
        wreq = 1'b1;
        cyc(1);
        wreq = 1'b0;
        cyc(3);
        blk = !q && !wp && sw && t != MFPC_T_OTHER;
        cmp("grant", {8'h00, !blk}, 9'(n_grant - g0));
    endtask

    task automatic hwrst(input logic en, q, s, input int lo, input int e);
        int r0;
        cfg2 = {2'h0, en, 5'h00};
        cfg1 = {6'h00, q, 1'b0};
        cyc(3);
        r0 = n_rst;
        if (s) host.sel();
        host.pins(4'h7, 4'hc);
        cyc(lo);
        cmp("frame", {8'h00, s}, {8'h00, fact});
        host.pins(4'hf, 4'hc);
        if (s) host.desel(1'b1);
        cyc(6);
        cmp("hw reset", 9'(e), 9'(n_rst - r0));
    endtask

    task automatic end_of_test();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        #1_000_000;
        n_fail++;
        end_of_test();
    end

    initial begin
        void'($urandom(5));
        cyc(3);
        rst_n = 1'b1;
        cyc(3);
        cmp("idle oe", 9'h0, {5'h00, io_oe});
        cmp("idle busy", 9'h0, {8'h00, wip});
        wframe(MFPC_W1, 1'b0, 1'b0, 1'b0);
        wframe(MFPC_W2, 1'b0, 1'b0, 1'b0);
        wframe(MFPC_W4, 1'b0, 1'b0, 1'b1);
        wframe(MFPC_W4, 1'b1, 1'b0, 1'b1);
        wframe(MFPC_W4, 1'b0, 1'b1, 1'b1);
        wframe(MFPC_W2, 1'b0, 1'b1, 1'b0);
        rframe(MFPC_W1, 0);
        rframe(MFPC_W4, 2);
        rframe(MFPC_W2, 1);
        for (int i = 0; i < 21; i++) begin
            if (i < 8) regw(i[0], i[1], i[2], MFPC_T_CONFIG1_V);
            else if (i < 13) regw(0, 0, 1, mfpc_target_t'(i - 8));
            else regw(1'($urandom), 1'($urandom), 1'($urandom),
                mfpc_target_t'($urandom % 5));
        end
        ops = 1'b1;
        cyc(1);
        ops = 1'b0;
        cyc(2);
        cmp("busy set", 9'h1, {8'h00, wip});
        cyc(1 + $urandom % 20);
        cmp("busy held", 9'h1, {8'h00, wip});
        opd = 1'b1;
        cyc(1);
        opd = 1'b0;
        cyc(2);
        cmp("busy clear", 9'h0, {8'h00, wip});
        hwrst(1'b1, 1'b0, 1'b0, 10, 1);
        hwrst(1'b1, 1'b0, 1'b0, 4, 1);
        hwrst(1'b1, 1'b0, 1'b0, 2, 0);
        hwrst(1'b1, 1'b1, 1'b0, 10, 1);
        hwrst(1'b1, 1'b1, 1'b1, 10, 0);
        hwrst(1'b0, 1'b0, 1'b0, 10, 0);
        end_of_test();
    end
endmodule
